// ===== core/sepc_pkg.sv
// Constants, register map and helpers for the spindle encoder position counter
// Function
// - Count each lone A or B edge, four per line; both at once is an error
// - Clear position on index rising edge
// - Select code 0 enables motor and card sources
// - Card speed when fitted, else motor generator
// - Absolute position only from position detect input
// - Adjuster inside plus/minus 11.25 degrees, else pattern
// - Scale spindle speed by gear correction coefficient
// - Reference is forward index edge; reverse shifts
// - Resolution codes -3..3 give 128..8192 lines
package sepc_pkg;

    // ------------------------------------------------------------
    // Register indexes
    // ------------------------------------------------------------
    localparam logic [3:0] SEPC_REG_CTRL = 4'h0;
    localparam logic [3:0] SEPC_REG_TARGET = 4'h1;
    localparam logic [3:0] SEPC_REG_LINES = 4'h2;
    localparam logic [3:0] SEPC_REG_GEAR = 4'h3;
    localparam logic [3:0] SEPC_REG_POS = 4'h4;
    localparam logic [3:0] SEPC_REG_SPEED = 4'h5;
    localparam logic [3:0] SEPC_REG_STATUS = 4'h6;
    localparam logic [3:0] SEPC_REG_DEV = 4'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SEPC_CTRL_SRC = 0;
    localparam int SEPC_CTRL_RES_LO = 4;
    localparam int SEPC_ST_ZONE = 0;
    localparam int SEPC_ST_CARD = 1;
    localparam int SEPC_ST_SPINDLE = 2;
    localparam int SEPC_ST_DIR = 3;
    localparam int SEPC_ST_INDEX = 4;
    localparam int SEPC_ST_ERR = 5;

    // ------------------------------------------------------------
    // Reset values and scaling
    // ------------------------------------------------------------
    localparam logic [15:0] SEPC_LINES_RST = 16'h0400;
    localparam logic [15:0] SEPC_GEAR_RST = 16'h1000;
    localparam int SEPC_GEAR_FRAC = 12;
    localparam int SEPC_ZONE_SHIFT = 5;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SEPC_CLK_MHZ = 50;
    localparam int SEPC_SAMPLE_US = 1000;
    localparam int SEPC_SAMPLE_CYC = SEPC_SAMPLE_US * SEPC_CLK_MHZ;

    // Counts per revolution for a resolution code, four per line
    function automatic logic [16:0] sepc_cpr(input logic [2:0] code);
        logic [16:0] cpr;
        cpr = 17'h01000;
        case (code)
            3'b101: cpr = 17'h00200;
            3'b110: cpr = 17'h00400;
            3'b111: cpr = 17'h00800;
            3'b001: cpr = 17'h02000;
            3'b010: cpr = 17'h04000;
            3'b011: cpr = 17'h08000;
            default: cpr = 17'h01000;
        endcase
        return cpr;
    endfunction

endpackage

// ===== core/sepc_quad.sv
// Quadrature edge decoder producing one step per lone A or B edge, none when both move
`timescale 1ns/1ns
module sepc_quad
    import sepc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic a,
    input wire logic b,
    output logic step,
    output logic dir,
    output logic err
);

    logic a_prev;
    logic b_prev;
    logic a_chg;
    logic b_chg;

    assign a_chg = a ^ a_prev;
    assign b_chg = b ^ b_prev;

    // ------------------------------------------------------------
    // Previous phase levels
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_prev <= 1'b0;
            b_prev <= 1'b0;
        end else begin
            a_prev <= a;
            b_prev <= b;
        end
    end

    // ------------------------------------------------------------
    // Step and direction
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step <= 1'b0;
            dir <= 1'b0;
            err <= 1'b0;
        end else begin
            step <= a_chg ^ b_chg;
            err <= a_chg & b_chg;
            if (a_chg ^ b_chg) begin
                dir <= a ^ b_prev;
            end
        end
    end

endmodule // sepc_quad

// ===== core/sepc_top.sv
// Spindle encoder position counter, speed source selection and zone judgment
`timescale 1ns/1ns
module sepc_top
    import sepc_pkg::*;
#(
    parameter int SAMPLE_CYC = SEPC_SAMPLE_CYC
)
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic POS_A,
    input wire logic POS_B,
    input wire logic POS_Z,
    input wire logic MPG_A,
    input wire logic MPG_B,
    input wire logic SDC_A,
    input wire logic SDC_B,
    input wire logic SDC_FITTED,
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    output logic [15:0] POSITION,
    output logic [15:0] DEVIATION,
    output logic [15:0] SPEED_FEEDBACK,
    output logic ADJUSTER_ACTIVE,
    output logic PATTERN_ACTIVE,
    output logic SPEED_FROM_CARD,
    output logic SPEED_FROM_SPINDLE,
    output logic COUNT_DIR
);

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic speed_source_select;
    logic [2:0] encoder_resolution_select;
    logic [15:0] target;
    logic [15:0] motor_encoder_line_count;
    logic [15:0] gear_correction_coefficient;
    logic pos_step;
    logic pos_dir;
    logic pos_err;
    logic mpg_step;
    logic mpg_dir;
    logic mpg_err;
    logic sdc_step;
    logic sdc_dir;
    logic sdc_err;
    logic z_prev;
    logic z_rise;
    logic index_seen;
    logic phase_err;
    logic [16:0] cpr;
    logic [15:0] pos_count;
    logic [16:0] dev_raw;
    logic [16:0] dev_wrap;
    logic [16:0] dev_abs;
    logic in_zone;
    logic use_card;
    logic use_spindle;
    logic sel_step;
    logic sel_dir;
    logic [15:0] speed_acc;
    logic [31:0] window_cnt;
    logic window_end;
    logic [32:0] scaled;
    logic [15:0] next_speed;
    logic [15:0] status;
    logic wr_ctrl;
    logic wr_status;

    assign cpr = sepc_cpr(encoder_resolution_select);

    // ------------------------------------------------------------
    // Quadrature decoders
    // ------------------------------------------------------------
    sepc_quad u_pos_quad (
        .clk(CLOCK),
        .rst_n(rst_n),
        .a(POS_A),
        .b(POS_B),
        .step(pos_step),
        .dir(pos_dir),
        .err(pos_err)
    );

    sepc_quad u_mpg_quad (
        .clk(CLOCK),
        .rst_n(rst_n),
        .a(MPG_A),
        .b(MPG_B),
        .step(mpg_step),
        .dir(mpg_dir),
        .err(mpg_err)
    );

    sepc_quad u_sdc_quad (
        .clk(CLOCK),
        .rst_n(rst_n),
        .a(SDC_A),
        .b(SDC_B),
        .step(sdc_step),
        .dir(sdc_dir),
        .err(sdc_err)
    );

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    assign wr_ctrl = REG_WR && (REG_ADDR == SEPC_REG_CTRL);
    assign wr_status = REG_WR && (REG_ADDR == SEPC_REG_STATUS);

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            speed_source_select <= 1'b0;
            encoder_resolution_select <= 3'h0;
            target <= 16'h0000;
            motor_encoder_line_count <= SEPC_LINES_RST;
            gear_correction_coefficient <= SEPC_GEAR_RST;
        end else if (REG_WR) begin
            if (wr_ctrl) begin
                speed_source_select <= REG_WDATA[SEPC_CTRL_SRC];
                encoder_resolution_select <= REG_WDATA[SEPC_CTRL_RES_LO +: 3];
            end else if (REG_ADDR == SEPC_REG_TARGET) begin
                target <= REG_WDATA;
            end else if (REG_ADDR == SEPC_REG_LINES) begin
                motor_encoder_line_count <= REG_WDATA;
            end else if (REG_ADDR == SEPC_REG_GEAR) begin
                gear_correction_coefficient <= REG_WDATA;
            end
        end
    end

    // ------------------------------------------------------------
    // Index edge and sticky flags
    // ------------------------------------------------------------
    assign z_rise = POS_Z & ~z_prev;

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            z_prev <= 1'b0;
        end else begin
            z_prev <= POS_Z;
        end
    end

    // Writing ones to the status word clears flags; a new event wins
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            index_seen <= 1'b0;
            phase_err <= 1'b0;
        end else begin
            if (z_rise) begin
                index_seen <= 1'b1;
            end else if (wr_status && REG_WDATA[SEPC_ST_INDEX]) begin
                index_seen <= 1'b0;
            end
            if (pos_err || mpg_err || sdc_err) begin
                phase_err <= 1'b1;
            end else if (wr_status && REG_WDATA[SEPC_ST_ERR]) begin
                phase_err <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Position counter
    // ------------------------------------------------------------
    // Only the position detect input carries the index, so it alone
    // drives the absolute count.
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            pos_count <= 16'h0000;
        end else if (z_rise) begin
            // Rising index edge is the datum; in reverse it lands
            // one index width away, a known offset.
            pos_count <= 16'h0000;
        end else if (pos_step) begin
            if (pos_dir) begin
                if ({1'b0, pos_count} >= cpr - 17'h00001) begin
                    pos_count <= 16'h0000;
                end else begin
                    pos_count <= pos_count + 16'h0001;
                end
            end else begin
                if (pos_count == 16'h0000 || {1'b0, pos_count} >= cpr) begin
                    pos_count <= 16'(cpr - 17'h00001);
                end else begin
                    pos_count <= pos_count - 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Deviation and control zone
    // ------------------------------------------------------------
    always_comb begin
        dev_raw = {1'b0, pos_count} - {1'b0, target};
        if (pos_count < target) begin
            dev_raw = dev_raw + cpr;
        end
        if (dev_raw >= {1'b0, cpr[16:1]}) begin
            dev_wrap = dev_raw - cpr;
        end else begin
            dev_wrap = dev_raw;
        end
        if (dev_wrap[16]) begin
            dev_abs = 17'h00000 - dev_wrap;
        end else begin
            dev_abs = dev_wrap;
        end
    end

    // One thirty-second of a turn is 11.25 degrees
    assign in_zone = dev_abs <= (cpr >> SEPC_ZONE_SHIFT);

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            ADJUSTER_ACTIVE <= 1'b0;
            PATTERN_ACTIVE <= 1'b1;
            DEVIATION <= 16'h0000;
            POSITION <= 16'h0000;
            COUNT_DIR <= 1'b0;
        end else begin
            ADJUSTER_ACTIVE <= in_zone;
            PATTERN_ACTIVE <= ~in_zone;
            DEVIATION <= dev_wrap[15:0];
            POSITION <= pos_count;
            COUNT_DIR <= pos_dir;
        end
    end

    // ------------------------------------------------------------
    // Speed source selection
    // ------------------------------------------------------------
    // Code 0 enables both motor-side sources and prefers the card
    assign use_spindle = speed_source_select;
    assign use_card = ~speed_source_select & SDC_FITTED;

    always_comb begin
        sel_step = mpg_step;
        sel_dir = mpg_dir;
        if (use_spindle) begin
            sel_step = pos_step;
            sel_dir = pos_dir;
        end else if (use_card) begin
            sel_step = sdc_step;
            sel_dir = sdc_dir;
        end
    end

    // ------------------------------------------------------------
    // Speed sampling window
    // ------------------------------------------------------------
    assign window_end = window_cnt >= 32'(SAMPLE_CYC - 1);

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            window_cnt <= 32'h00000000;
        end else if (window_end) begin
            window_cnt <= 32'h00000000;
        end else begin
            window_cnt <= window_cnt + 32'h00000001;
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            speed_acc <= 16'h0000;
        // A step on the closing edge opens the next window rather than being lost
        end else if (!sel_step) begin
            speed_acc <= window_end ? 16'h0000 : speed_acc;
        end else if (sel_dir) begin
            speed_acc <= (window_end ? 16'h0000 : speed_acc) + 16'h0001;
        end else begin
            speed_acc <= (window_end ? 16'h0000 : speed_acc) - 16'h0001;
        end
    end

    // Gear ratio correction applies only to the spindle encoder
    assign scaled = 33'($signed(speed_acc) * $signed({1'b0, gear_correction_coefficient}));

    always_comb begin
        next_speed = speed_acc;
        if (use_spindle) begin
            next_speed = scaled[SEPC_GEAR_FRAC +: 16];
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            SPEED_FEEDBACK <= 16'h0000;
            SPEED_FROM_CARD <= 1'b0;
            SPEED_FROM_SPINDLE <= 1'b0;
        end else begin
            if (window_end) begin
                SPEED_FEEDBACK <= next_speed;
            end
            SPEED_FROM_CARD <= use_card;
            SPEED_FROM_SPINDLE <= use_spindle;
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always_comb begin
        status = 16'h0000;
        status[SEPC_ST_ZONE] = ADJUSTER_ACTIVE;
        status[SEPC_ST_CARD] = SPEED_FROM_CARD;
        status[SEPC_ST_SPINDLE] = SPEED_FROM_SPINDLE;
        status[SEPC_ST_DIR] = COUNT_DIR;
        status[SEPC_ST_INDEX] = index_seen;
        status[SEPC_ST_ERR] = phase_err;
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= 16'h0000;
        end else if (!REG_RD) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_ADDR == SEPC_REG_CTRL) begin
            REG_RDATA <= {9'h000, encoder_resolution_select, 3'h0, speed_source_select};
        end else if (REG_ADDR == SEPC_REG_TARGET) begin
            REG_RDATA <= target;
        end else if (REG_ADDR == SEPC_REG_LINES) begin
            REG_RDATA <= motor_encoder_line_count;
        end else if (REG_ADDR == SEPC_REG_GEAR) begin
            REG_RDATA <= gear_correction_coefficient;
        end else if (REG_ADDR == SEPC_REG_POS) begin
            REG_RDATA <= POSITION;
        end else if (REG_ADDR == SEPC_REG_SPEED) begin
            REG_RDATA <= SPEED_FEEDBACK;
        end else if (REG_ADDR == SEPC_REG_STATUS) begin
            REG_RDATA <= status;
        end else if (REG_ADDR == SEPC_REG_DEV) begin
            REG_RDATA <= DEVIATION;
        end else begin
            REG_RDATA <= 16'h0000;
        end
    end

endmodule // sepc_top

// ===== sim/sepc_top_monitor.sv
// Port-level assertion checker for the spindle encoder position counter
`timescale 1ns/1ns
module sepc_top_monitor
    import sepc_pkg::*;
#(
    parameter int SAMPLE_CYC = SEPC_SAMPLE_CYC
)
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic POS_A,
    input wire logic POS_B,
    input wire logic POS_Z,
    input wire logic SDC_FITTED,
    input wire logic REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic [15:0] POSITION,
    input wire logic [15:0] DEVIATION,
    input wire logic ADJUSTER_ACTIVE,
    input wire logic PATTERN_ACTIVE,
    input wire logic SPEED_FROM_CARD,
    input wire logic SPEED_FROM_SPINDLE,
    input wire logic COUNT_DIR
);
    default clocking mon_clk @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);

    adj_pat_excl_a: assert property (ADJUSTER_ACTIVE != PATTERN_ACTIVE)
        else $error("adjuster and pattern flags agree");
    zone_dev_a: assert property (ADJUSTER_ACTIVE |-> ($signed(DEVIATION) <= 16'sh0400)
        && ($signed(DEVIATION) >= -16'sh0400))
        else $error("adjuster active with deviation beyond the widest zone");
    src_excl_a: assert property (!(SPEED_FROM_CARD && SPEED_FROM_SPINDLE))
        else $error("card and spindle both selected for speed");
    card_absent_a: assert property (!SDC_FITTED [*4] |-> !SPEED_FROM_CARD)
        else $error("card selected while not fitted");
    index_clear_a: assert property ($rose(POS_Z) |-> ##[1:4] (POSITION == 16'h0000))
        else $error("position not cleared after index rise");
    dir_up_a: assert property ($rose(POS_A) && !POS_B && $stable(POS_B) |-> ##[1:4] COUNT_DIR)
        else $error("A leading B did not count up");
    dir_down_a: assert property ($rose(POS_B) && !POS_A && $stable(POS_A) |-> ##[1:4] !COUNT_DIR)
        else $error("B leading A did not count down");
    pos_step_a: assert property ($changed(POSITION) |-> (POSITION == $past(POSITION) + 16'h0001)
        || (POSITION == $past(POSITION) - 16'h0001) || (POSITION == 16'h0000)
        || ($past(POSITION) == 16'h0000))
        else $error("position moved by more than one count");
    pos_hold_a: assert property (($stable(POS_A) && $stable(POS_B) && $stable(POS_Z)) [*4]
        |=> $stable(POSITION))
        else $error("position moved with quiet encoder");
    rdata_idle_a: assert property (REG_RDATA != 16'h0000 |-> $past(REG_RD))
        else $error("read data outside the read answer cycle");
endmodule // sepc_top_monitor

bind sepc_top sepc_top_monitor #(.SAMPLE_CYC(SAMPLE_CYC)) sepc_top_monitor_inst (
    .CLOCK(CLOCK), .RSTN(RSTN), .POS_A(POS_A), .POS_B(POS_B), .POS_Z(POS_Z),
    .SDC_FITTED(SDC_FITTED), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .POSITION(POSITION),
    .DEVIATION(DEVIATION), .ADJUSTER_ACTIVE(ADJUSTER_ACTIVE), .PATTERN_ACTIVE(PATTERN_ACTIVE),
    .SPEED_FROM_CARD(SPEED_FROM_CARD), .SPEED_FROM_SPINDLE(SPEED_FROM_SPINDLE),
    .COUNT_DIR(COUNT_DIR));

// ===== sim/sepc_encoder_model.sv
// Behavioural incremental quadrature encoder with index output
`timescale 1ns/1ns
module sepc_encoder_model (
    input wire logic clk,
    output logic a,
    output logic b,
    output logic z
);
    initial begin
        a = 1'b0;
        b = 1'b0;
        z = 1'b0;
    end

    // Gray sequence; forward lets A lead B, gap sets the speed
    task automatic turn(input int steps, input bit fwd, input int gap);
        for (int i = 0; i < steps; i++) begin
            @(posedge clk);
            if ((a == b) == fwd)
                a <= ~a;
            else
                b <= ~b;
            repeat (gap - 1) @(posedge clk);
        end
    endtask

    task automatic mark_index(input int width);
        @(posedge clk);
        z <= 1'b1;
        repeat (width) @(posedge clk);
        z <= 1'b0;
    endtask

    // Both phases move in one cycle, a glitch the decoder must refuse
    task automatic jolt();
        @(posedge clk);
        a <= ~a;
        b <= ~b;
    endtask
endmodule // sepc_encoder_model

// ===== sim/test_spindle_encoder_position_counter.sv
// Self-checking testbench for the spindle encoder position counter
`timescale 1ns/1ns
module test_spindle_encoder_position_counter;
    import sepc_pkg::*;
    logic CLOCK, RSTN, SDC_FITTED, REG_WR, REG_RD;
    logic POS_A, POS_B, POS_Z, MPG_A, MPG_B, SDC_A, SDC_B;
    logic [3:0] REG_ADDR;
    logic [15:0] REG_WDATA, REG_RDATA, POSITION, DEVIATION, SPEED_FEEDBACK;
    logic ADJUSTER_ACTIVE, PATTERN_ACTIVE, SPEED_FROM_CARD, SPEED_FROM_SPINDLE, COUNT_DIR;
    int error_cnt = 0;
    int checked = 0;

    sepc_top #(.SAMPLE_CYC(16)) sepc_top_inst (
        .CLOCK(CLOCK), .RSTN(RSTN), .POS_A(POS_A), .POS_B(POS_B), .POS_Z(POS_Z),
        .MPG_A(MPG_A), .MPG_B(MPG_B), .SDC_A(SDC_A), .SDC_B(SDC_B), .SDC_FITTED(SDC_FITTED),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .POSITION(POSITION), .DEVIATION(DEVIATION),
        .SPEED_FEEDBACK(SPEED_FEEDBACK), .ADJUSTER_ACTIVE(ADJUSTER_ACTIVE),
        .PATTERN_ACTIVE(PATTERN_ACTIVE), .SPEED_FROM_CARD(SPEED_FROM_CARD),
        .SPEED_FROM_SPINDLE(SPEED_FROM_SPINDLE), .COUNT_DIR(COUNT_DIR));
    sepc_encoder_model pos_enc (.clk(CLOCK), .a(POS_A), .b(POS_B), .z(POS_Z));
    sepc_encoder_model mpg_enc (.clk(CLOCK), .a(MPG_A), .b(MPG_B), .z());
    sepc_encoder_model sdc_enc (.clk(CLOCK), .a(SDC_A), .b(SDC_B), .z());

    initial begin
        CLOCK = 1'b0;
        forever #10 CLOCK = ~CLOCK;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [3:0] addr, input logic [15:0] data);
        @(posedge CLOCK);
        REG_WR <= 1'b1;
        REG_ADDR <= addr;
        REG_WDATA <= data;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
    endtask

    task automatic read_check(input logic [3:0] addr, input logic [15:0] exp, input string what);
        @(posedge CLOCK);
        REG_RD <= 1'b1;
        REG_ADDR <= addr;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
        #1;
        check_word(what, exp, REG_RDATA);
    endtask

    task automatic settle();
        repeat (5) @(posedge CLOCK);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_registers();
        read_check(SEPC_REG_CTRL, 16'h0000, "ctrl reset");
        read_check(SEPC_REG_LINES, 16'h0400, "lines reset");
        read_check(SEPC_REG_GEAR, 16'h1000, "gear reset");
        reg_write(SEPC_REG_TARGET, 16'h5A5A);
        read_check(SEPC_REG_TARGET, 16'h5A5A, "target");
        reg_write(SEPC_REG_POS, 16'h1234);
        read_check(SEPC_REG_POS, 16'h0000, "position read-only");
        reg_write(4'h8, 16'hFFFF);
        read_check(4'h8, 16'h0000, "unmapped");
        $display("test_registers done");
    endtask

    task automatic test_counting();
        pos_enc.turn(10, 1'b1, 2);
        settle();
        check_word("forward count", 16'h000A, POSITION);
        check_bit("up direction", 1'b1, COUNT_DIR);
        pos_enc.turn(3, 1'b0, 3);
        settle();
        check_word("reverse count", 16'h0007, POSITION);
        check_bit("down direction", 1'b0, COUNT_DIR);
        read_check(SEPC_REG_POS, 16'h0007, "position register");
        $display("test_counting done");
    endtask

    task automatic test_resolution();
        logic [2:0] codes [7] = '{3'b101, 3'b110, 3'b111, 3'b000, 3'b001, 3'b010, 3'b011};
        logic [15:0] tops [7] = '{16'h01FF, 16'h03FF, 16'h07FF, 16'h0FFF,
                                  16'h1FFF, 16'h3FFF, 16'h7FFF};
        for (int i = 0; i < 7; i++) begin
            reg_write(SEPC_REG_CTRL, {9'h000, codes[i], 4'h0});
            pos_enc.mark_index(7);
            settle();
            check_word("index clear", 16'h0000, POSITION);
            pos_enc.turn(1, 1'b0, 2);
            settle();
            check_word("wrap below zero", tops[i], POSITION);
        end
        $display("test_resolution done");
    endtask

    task automatic test_zone();
        logic [15:0] targets [3] = '{16'h0080, 16'h0081, 16'h0F80};
        logic [15:0] devs [3] = '{16'hFF80, 16'hFF7F, 16'h0080};
        logic adj [3] = '{1'b1, 1'b0, 1'b1};
        reg_write(SEPC_REG_CTRL, 16'h0000);
        pos_enc.mark_index(3);
        for (int i = 0; i < 3; i++) begin
            reg_write(SEPC_REG_TARGET, targets[i]);
            settle();
            check_word("deviation", devs[i], DEVIATION);
            check_bit("adjuster zone", adj[i], ADJUSTER_ACTIVE);
            check_bit("pattern zone", ~adj[i], PATTERN_ACTIVE);
        end
        read_check(SEPC_REG_STATUS, 16'h0011, "status index");
        sdc_enc.jolt();
        settle();
        read_check(SEPC_REG_STATUS, 16'h0031, "status phase error");
        reg_write(SEPC_REG_STATUS, 16'h0030);
        read_check(SEPC_REG_STATUS, 16'h0001, "status cleared");
        $display("test_zone done");
    endtask

    task automatic speed_case(input logic [15:0] ctrl, input logic fitted, input int src,
                              input bit fwd, input logic [15:0] exp, input logic card,
                              input logic spin);
        reg_write(SEPC_REG_CTRL, ctrl);
        SDC_FITTED <= fitted;
        fork
            if (src == 0)
                pos_enc.turn(40, fwd, 4);
            else if (src == 1)
                mpg_enc.turn(40, fwd, 4);
            else
                sdc_enc.turn(40, fwd, 4);
            begin
                repeat (100) @(posedge CLOCK);
                #1;
                check_word("speed feedback", exp, SPEED_FEEDBACK);
                check_bit("card selected", card, SPEED_FROM_CARD);
                check_bit("spindle selected", spin, SPEED_FROM_SPINDLE);
            end
        join
    endtask

    task automatic test_speed();
        reg_write(SEPC_REG_GEAR, 16'h2000);
        speed_case(16'h0001, 1'b0, 0, 1'b1, 16'h0008, 1'b0, 1'b1);
        speed_case(16'h0000, 1'b0, 1, 1'b1, 16'h0004, 1'b0, 1'b0);
        speed_case(16'h0000, 1'b1, 2, 1'b0, 16'hFFFC, 1'b1, 1'b0);
        $display("test_speed done");
    endtask

    initial begin
        repeat (20000) @(posedge CLOCK);
        error_cnt++;
        $display("unexpected run end: expected finished, seen still running");
        test_done();
    end

    initial begin
        RSTN = 1'b0;
        SDC_FITTED = 1'b0;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_ADDR = 4'h0;
        REG_WDATA = 16'h0000;
        repeat (3) @(posedge CLOCK);
        RSTN <= 1'b1;
        repeat (3) @(posedge CLOCK);
        test_registers();
        test_counting();
        test_resolution();
        test_zone();
        test_speed();
        test_done();
    end
endmodule // test_spindle_encoder_position_counter
